// >>> logic/acqes_defs.vh
// Register offsets, field positions, reset values and timing counts for the
// acquisition control and event status block.
// Assumes a 20 MHz system clock and a 32-bit word-wide register port.
`ifndef ACQES_DEFS_VH
`define ACQES_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ACQES_OFS_BOARD_CONTROL   8'h00
`define ACQES_OFS_DIGITAL_PORT    8'h04
`define ACQES_OFS_PACER_ONE       8'h1C
`define ACQES_OFS_PACER_TWO       8'h20
`define ACQES_OFS_THRESHOLD       8'h2C
`define ACQES_OFS_EVENT_STATUS    8'h30

// ****************************************************************
// Board control register fields
// ****************************************************************
`define ACQES_BC_INIT             0
`define ACQES_BC_CAL_START        1
`define ACQES_BC_CAL_OK           2
`define ACQES_BC_STRAIGHT_CODE    3
`define ACQES_BC_PACER_ONE_EN     4
`define ACQES_BC_PACER_TWO_EN     5
`define ACQES_BC_HIGH_RATE        6
`define ACQES_BC_BURST_EN         7
`define ACQES_BC_CLK_SEL_LO       8
`define ACQES_BC_TRIG_SEL_LO      10
`define ACQES_BC_HIGH_RANGE       12
`define ACQES_BC_FILTER_EN        13
`define ACQES_BC_BURST_ACTIVE     14
`define ACQES_BC_FILL_FLAG        15

// ****************************************************************
// Digital port fields
// ****************************************************************
`define ACQES_DP_LOW_DRIVE        7
`define ACQES_DP_HIGH_DATA_LO     8
`define ACQES_DP_HIGH_DRIVE       15

// ****************************************************************
// Source selector encodings
// ****************************************************************
`define ACQES_SRC_DEFAULT         2'h0
`define ACQES_SRC_SWAPPED         2'h1
`define ACQES_SRC_EXTERNAL        2'h2

// ****************************************************************
// Reset values
// ****************************************************************
`define ACQES_PACER_ONE_RESET     24'h0001C2
`define ACQES_PACER_TWO_RESET     24'h002BF2
`define ACQES_THRESHOLD_RESET     19'h3FFFE
`define ACQES_EVENT_STATUS_RESET  32'h00000000

// ****************************************************************
// Timing
// ****************************************************************
`define ACQES_CLK_HZ              20000000
`define ACQES_CAL_NOFILT_MS       4000
`define ACQES_CAL_FILT_MS         7000

`endif

// >>> logic/acqes_pacer.v
// Programmable rate divider producing one-cycle ticks.
// Assumes the divisor is stable while enabled; a change enters the wrap compare
// at once, in the middle of the count.
`timescale 1ns/1ns
`default_nettype none

module acqes_pacer (
    // Clock, reset and freeze
    input  wire        clk_sys,
    input  wire        reset,
    input  wire        ce,
    // Control
    input  wire        enable,
    input  wire [23:0] rate_divisor,
    // Tick output
    output reg         tick
);

    reg  [23:0] count;
    wire        wrap;

    // The count wraps once it reaches the divisor; zero and one tick every cycle.
    assign wrap = (count >= rate_divisor);

    // ****************************************************************
    // Divider
    // ****************************************************************

    // Counts clock cycles while enabled and holds at one while stopped.
    always @(posedge clk_sys) begin
        if (reset) begin
            count <= 24'h000001;
            tick  <= 1'b0;
        end else if (ce) begin
            if (!enable) begin
                count <= 24'h000001;
                tick  <= 1'b0;
            end else if (wrap) begin
                count <= 24'h000001;
                tick  <= 1'b1;
            end else begin
                count <= count + 24'h000001;
                tick  <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// >>> logic/acqes_top.v
// Control registers, rate dividers, sync sharing, digital port, calibration
// sequencing and event status of the analog acquisition board.
// Assumes a synchronous word-wide register port and synchronous pin inputs.
`timescale 1ns/1ns
`default_nettype none

`include "acqes_defs.vh"

module acqes_top #(
    parameter CAL_NOFILT_CYCLES = `ACQES_CAL_NOFILT_MS * (`ACQES_CLK_HZ / 1000),
    parameter CAL_FILT_CYCLES   = `ACQES_CAL_FILT_MS * (`ACQES_CLK_HZ / 1000)
) (
    // Clock, reset and freeze
    input  wire        clk_sys,
    input  wire        reset,
    input  wire        ce,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // Converter data
    input  wire [17:0] adc_sample,
    input  wire        adc_valid,
    output reg  [17:0] sample_data,
    output reg         sample_valid,
    // Buffer and burst status from the data path
    input  wire [18:0] buffer_count,
    input  wire        buffer_fault,
    input  wire        burst_end,
    // Multiboard clock and trigger
    input  wire        ext_clock_in,
    input  wire        ext_trigger_in,
    output reg         sample_clock,
    output reg         burst_trigger,
    output reg         clock_target,
    output reg         trigger_target,
    output reg         burst_active,
    output reg         high_rate_mode,
    // Digital lines
    input  wire [7:0]  dio_in,
    output reg  [7:0]  dio_out,
    output reg  [7:0]  dio_oe,
    // Calibration engine
    input  wire        cal_fail,
    output reg         cal_running,
    output reg         cal_range,
    output reg         cal_filter,
    output reg         cal_valid
);

    localparam [27:0] CAL_NOFILT = CAL_NOFILT_CYCLES[27:0];
    localparam [27:0] CAL_FILT   = CAL_FILT_CYCLES[27:0];

    // ****************************************************************
    // Register state
    // ****************************************************************

    reg         straight_code;
    reg         pacer_one_en;
    reg         pacer_two_en;
    reg         burst_en;
    reg  [1:0]  clock_sel;
    reg  [1:0]  trigger_sel;
    reg         high_range;
    reg         filter_en;
    reg         cal_start;
    reg         cal_ok;
    reg  [23:0] pacer_one_div;
    reg  [23:0] pacer_two_div;
    reg  [18:0] threshold;
    reg  [7:0]  dio_low_high;
    reg         low_nibble_drive;
    reg         high_nibble_drive;
    reg  [7:0]  event_select;
    reg  [7:0]  event_response;
    reg         fill_level_flag;
    reg         init_req;
    reg  [27:0] cal_count;
    reg         ext_clock_prev;
    reg         ext_trigger_prev;
    reg         fill_prev;
    reg         burst_prev;
    reg         dio0_prev;
    reg         cal_done;

    wire        pacer_one_tick;
    wire        pacer_two_tick;
    wire        soft_reset;
    wire        wr_bc;
    wire        wr_es;
    reg         next_clock;
    reg         next_trigger;
    reg  [7:0]  event_hit;
    reg  [31:0] next_rdata;

    assign soft_reset = reset | init_req;
    assign wr_bc      = reg_wr && (reg_addr == `ACQES_OFS_BOARD_CONTROL);
    assign wr_es      = reg_wr && (reg_addr == `ACQES_OFS_EVENT_STATUS);

    // ****************************************************************
    // Rate dividers
    // ****************************************************************

    // Two identical dividers, each gated by its own enable bit.
    acqes_pacer u_pacer_one (
        .clk_sys      (clk_sys),
        .reset        (soft_reset),
        .ce           (ce),
        .enable       (pacer_one_en),
        .rate_divisor (pacer_one_div),
        .tick         (pacer_one_tick)
    );

    acqes_pacer u_pacer_two (
        .clk_sys      (clk_sys),
        .reset        (soft_reset),
        .ce           (ce),
        .enable       (pacer_two_en),
        .rate_divisor (pacer_two_div),
        .tick         (pacer_two_tick)
    );

    // ****************************************************************
    // Source selection
    // ****************************************************************

    // Picks the sample clock and burst trigger; external edges pass in one cycle.
    always @* begin
        case (clock_sel)
            `ACQES_SRC_DEFAULT:  next_clock = pacer_one_tick;
            `ACQES_SRC_SWAPPED:  next_clock = pacer_two_tick;
            `ACQES_SRC_EXTERNAL: next_clock = ext_clock_in & ~ext_clock_prev;
            default:             next_clock = 1'b0;
        endcase
        case (trigger_sel)
            `ACQES_SRC_DEFAULT:  next_trigger = pacer_two_tick;
            `ACQES_SRC_SWAPPED:  next_trigger = pacer_one_tick;
            `ACQES_SRC_EXTERNAL: next_trigger = ext_trigger_in & ~ext_trigger_prev;
            default:             next_trigger = 1'b0;
        endcase
    end

    // Registers the selected pulses and the initiator or target role.
    always @(posedge clk_sys) begin
        if (soft_reset) begin
            sample_clock     <= 1'b0;
            burst_trigger    <= 1'b0;
            clock_target     <= 1'b0;
            trigger_target   <= 1'b0;
            ext_clock_prev   <= 1'b0;
            ext_trigger_prev <= 1'b0;
            burst_active     <= 1'b0;
        end else if (ce) begin
            ext_clock_prev   <= ext_clock_in;
            ext_trigger_prev <= ext_trigger_in;
            sample_clock     <= next_clock;
            burst_trigger    <= next_trigger;
            clock_target     <= (clock_sel == `ACQES_SRC_EXTERNAL);
            trigger_target   <= (trigger_sel == `ACQES_SRC_EXTERNAL);
            // A trigger during a burst is ignored; the end drops the flag.
            if (!burst_en || burst_end) begin
                burst_active <= 1'b0;
            end else if (next_trigger) begin
                burst_active <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Sample coding and fill level
    // ****************************************************************

    // Offset binary passes through; two's complement flips the top bit.
    always @(posedge clk_sys) begin
        if (soft_reset) begin
            sample_data     <= 18'h00000;
            sample_valid    <= 1'b0;
            fill_level_flag <= 1'b0;
        end else if (ce) begin
            sample_valid    <= adc_valid;
            sample_data     <= {adc_sample[17] ^ ~straight_code, adc_sample[16:0]};
            fill_level_flag <= (buffer_count > threshold);
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************

    // Host writes; software init reloads every default on the next edge.
    always @(posedge clk_sys) begin
        if (soft_reset) begin
            init_req          <= 1'b0;
            straight_code     <= 1'b1;
            pacer_one_en      <= 1'b0;
            pacer_two_en      <= 1'b0;
            high_rate_mode    <= 1'b0;
            burst_en          <= 1'b0;
            clock_sel         <= `ACQES_SRC_DEFAULT;
            trigger_sel       <= `ACQES_SRC_DEFAULT;
            high_range        <= 1'b1;
            filter_en         <= 1'b0;
            pacer_one_div     <= `ACQES_PACER_ONE_RESET;
            pacer_two_div     <= `ACQES_PACER_TWO_RESET;
            threshold         <= `ACQES_THRESHOLD_RESET;
            dio_low_high      <= 8'h00;
            low_nibble_drive  <= 1'b0;
            high_nibble_drive <= 1'b0;
            event_select      <= 8'h00;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                `ACQES_OFS_BOARD_CONTROL: begin
                    init_req       <= reg_wdata[`ACQES_BC_INIT];
                    straight_code  <= reg_wdata[`ACQES_BC_STRAIGHT_CODE];
                    pacer_one_en   <= reg_wdata[`ACQES_BC_PACER_ONE_EN];
                    pacer_two_en   <= reg_wdata[`ACQES_BC_PACER_TWO_EN];
                    high_rate_mode <= reg_wdata[`ACQES_BC_HIGH_RATE];
                    burst_en       <= reg_wdata[`ACQES_BC_BURST_EN];
                    clock_sel      <= reg_wdata[`ACQES_BC_CLK_SEL_LO +: 2];
                    trigger_sel    <= reg_wdata[`ACQES_BC_TRIG_SEL_LO +: 2];
                    high_range     <= reg_wdata[`ACQES_BC_HIGH_RANGE];
                    filter_en      <= reg_wdata[`ACQES_BC_FILTER_EN];
                end
                `ACQES_OFS_DIGITAL_PORT: begin
                    dio_low_high      <= {reg_wdata[11:8], reg_wdata[3:0]};
                    low_nibble_drive  <= reg_wdata[`ACQES_DP_LOW_DRIVE];
                    high_nibble_drive <= reg_wdata[`ACQES_DP_HIGH_DRIVE];
                end
                `ACQES_OFS_PACER_ONE: pacer_one_div <= reg_wdata[23:0];
                `ACQES_OFS_PACER_TWO: pacer_two_div <= reg_wdata[23:0];
                `ACQES_OFS_THRESHOLD: threshold     <= reg_wdata[18:0];
                `ACQES_OFS_EVENT_STATUS: event_select <= reg_wdata[7:0];
                default: init_req <= 1'b0;
            endcase
        end else if (ce) begin
            init_req <= 1'b0;
        end
    end

    // Drives each nibble only while its direction bit is high.
    always @(posedge clk_sys) begin
        if (soft_reset) begin
            dio_out <= 8'h00;
            dio_oe  <= 8'h00;
        end else if (ce) begin
            dio_out <= dio_low_high;
            dio_oe  <= {{4{high_nibble_drive}}, {4{low_nibble_drive}}};
        end
    end

    // ****************************************************************
    // Calibration sequencer
    // ****************************************************************

    // Latches range and filter; the filter bit sets the interval; the start bit drops at the end.
    always @(posedge clk_sys) begin
        if (soft_reset) begin
            cal_start   <= 1'b0;
            cal_running <= 1'b0;
            cal_ok      <= 1'b1;
            cal_count   <= 28'h0000000;
            cal_done    <= 1'b0;
            cal_range   <= 1'b1;
            cal_filter  <= 1'b0;
        end else if (ce) begin
            cal_done <= 1'b0;
            if (wr_bc && reg_wdata[`ACQES_BC_CAL_START]) begin
                cal_start   <= 1'b1;
                cal_running <= 1'b1;
                cal_count   <= 28'h0000000;
                cal_range   <= reg_wdata[`ACQES_BC_HIGH_RANGE];
                cal_filter  <= reg_wdata[`ACQES_BC_FILTER_EN];
            end else if (cal_running) begin
                if (cal_count >= (cal_filter ? CAL_FILT : CAL_NOFILT) - 28'h0000001) begin
                    cal_start   <= 1'b0;
                    cal_running <= 1'b0;
                    cal_done    <= 1'b1;
                    cal_ok      <= ~cal_fail;
                end else begin
                    cal_count <= cal_count + 28'h0000001;
                end
            end
        end
    end

    // Stored corrections count as valid only after a pass; init keeps them.
    always @(posedge clk_sys) begin
        if (reset) begin
            cal_valid <= 1'b0;
        end else if (ce && cal_running) begin
            cal_valid <= 1'b0;
        end else if (ce && cal_done) begin
            cal_valid <= cal_ok;
        end
    end

    // ****************************************************************
    // Event status
    // ****************************************************************

    // Event sources in selection order; fill, burst and digital line 0 sources are edges.
    always @* begin
        event_hit[0] = cal_done;
        event_hit[1] = fill_prev & ~fill_level_flag;
        event_hit[2] = ~fill_prev & fill_level_flag;
        event_hit[3] = buffer_fault;
        event_hit[4] = ~burst_prev & burst_active;
        event_hit[5] = burst_prev & ~burst_active;
        event_hit[6] = sample_clock;
        event_hit[7] = ~dio0_prev & dio_in[0];
    end

    // Sticky responses: set wins over a host clear in the same cycle.
    always @(posedge clk_sys) begin
        if (soft_reset) begin
            event_response <= 8'h00;
            fill_prev      <= 1'b0;
            burst_prev     <= 1'b0;
            dio0_prev      <= 1'b0;
        end else if (ce) begin
            fill_prev      <= fill_level_flag;
            burst_prev     <= burst_active;
            dio0_prev      <= dio_in[0];
            if (wr_es) begin
                event_response <= (event_response & reg_wdata[23:16] & reg_wdata[7:0])
                                  | (event_hit & event_select & reg_wdata[7:0]);
            end else begin
                event_response <= (event_response & event_select) | (event_hit & event_select);
            end
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************

    // Assembles the addressed word; unmapped and reserved bits read zero.
    always @* begin
        next_rdata = 32'h00000000;
        case (reg_addr)
            `ACQES_OFS_BOARD_CONTROL: begin
                next_rdata[`ACQES_BC_CAL_START]        = cal_start;
                next_rdata[`ACQES_BC_CAL_OK]           = cal_ok;
                next_rdata[`ACQES_BC_STRAIGHT_CODE]    = straight_code;
                next_rdata[`ACQES_BC_PACER_ONE_EN]     = pacer_one_en;
                next_rdata[`ACQES_BC_PACER_TWO_EN]     = pacer_two_en;
                next_rdata[`ACQES_BC_HIGH_RATE]        = high_rate_mode;
                next_rdata[`ACQES_BC_BURST_EN]         = burst_en;
                next_rdata[`ACQES_BC_CLK_SEL_LO +: 2]  = clock_sel;
                next_rdata[`ACQES_BC_TRIG_SEL_LO +: 2] = trigger_sel;
                next_rdata[`ACQES_BC_HIGH_RANGE]       = high_range;
                next_rdata[`ACQES_BC_FILTER_EN]        = filter_en;
                next_rdata[`ACQES_BC_BURST_ACTIVE]     = burst_active;
                next_rdata[`ACQES_BC_FILL_FLAG]        = fill_level_flag;
            end
            `ACQES_OFS_DIGITAL_PORT: begin
                next_rdata[3:0]                 = dio_in[3:0];
                next_rdata[`ACQES_DP_LOW_DRIVE]  = low_nibble_drive;
                next_rdata[11:8]                = dio_in[7:4];
                next_rdata[`ACQES_DP_HIGH_DRIVE] = high_nibble_drive;
            end
            `ACQES_OFS_PACER_ONE: next_rdata = {8'h00, pacer_one_div};
            `ACQES_OFS_PACER_TWO: next_rdata = {8'h00, pacer_two_div};
            `ACQES_OFS_THRESHOLD: next_rdata = {11'h000, fill_level_flag, 1'b0, threshold};
            `ACQES_OFS_EVENT_STATUS: next_rdata = {8'h00, event_response, 8'h00, event_select};
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Read data is registered on the read strobe.
    always @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 32'h00000000;
        end else if (ce && reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

endmodule

`default_nettype wire

// >>> logic/acqes_top_dummy_none.v
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// >>> verification/acqes_top_chk.sv
// Checker on the top ports of the acquisition control block.
// Assumes ce held high and the shortened calibration counts.
`timescale 1ns/1ns
`default_nettype none
module acqes_top_chk #(parameter CAL_NOFILT_CYCLES = 20, CAL_FILT_CYCLES = 35) (
    input wire logic        clk_sys, reset, reg_wr, reg_rd, adc_valid, sample_valid, clock_target, cal_running,
    input wire logic [7:0]  reg_addr, dio_out, dio_oe,
    input wire logic [31:0] reg_wdata, reg_rdata
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Port, divisor, coding and calibration relations at the ports.
    init_role_a: assert property ($fell(reset) |-> !clock_target && dio_oe == 8'h00) else $error("bad reset role");
    nibble_dir_a: assert property (reg_wr && reg_addr == 8'h04 |-> ##2
        dio_oe == {{4{$past(reg_wdata[15], 2)}}, {4{$past(reg_wdata[7], 2)}}}) else $error("bad direction");
    line_out_a: assert property (reg_wr && reg_addr == 8'h04 |-> ##2
        dio_out[3:0] == $past(reg_wdata[3:0], 2)) else $error("bad line value");
    div_top_a: assert property (reg_rd && reg_addr inside {8'h1C, 8'h20} |=> reg_rdata[31:24] == 8'h00)
        else $error("bad divisor top");
    coding_out_a: assert property (adc_valid |=> sample_valid) else $error("no sample");
    cal_start_a: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[1:0] == 2'b10 |=> cal_running)
        else $error("no calibration");
    cal_bound_a: assert property ($rose(cal_running) |-> ##[1:40] !cal_running) else $error("calibration hung");
    role_sel_a: assert property (reg_wr && reg_addr == 8'h00 && !reg_wdata[0] |-> ##2
        clock_target == ($past(reg_wdata[9:8], 2) == 2'h2)) else $error("bad clock role");
    // Main scenarios reached.
    cover property ($fell(cal_running));
    cover property (sample_valid);
    cover property (dio_oe == 8'h0F);
endmodule
`default_nettype wire

// >>> verification/acqes_host.sv
// Host model driving the block's register port.
// Assumes strobes are taken at the rising edge after they are raised.
`timescale 1ns/1ns
`default_nettype none
module acqes_host (
    input wire logic        clk_sys,
    input wire logic [31:0] reg_rdata,
    output var logic        reg_wr = 1'b0, reg_rd = 1'b0,
    output var logic [7:0]  reg_addr = 8'h00,
    output var logic [31:0] reg_wdata = 32'h0
);
    // Writes one word; the strobe stands for one edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Reads one word, taken once the registered data has settled.
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys) #1 v = reg_rdata;
    endtask
endmodule
`default_nettype wire

// >>> verification/acqes_top_tb.sv
// Bench: host model and checker around the acquisition control block.
// Assumes shortened calibration; ce, trigger and burst end inputs are tied.
`timescale 1ns/1ns
`default_nettype none
module acqes_top_tb;
    logic clk_sys = 1'b0, reset = 1'b1, adc_valid = 1'b0, cal_fail = 1'b0, reg_wr, reg_rd, sample_clock, cal_running;
    logic ext_clk = 1'b0, fault = 1'b0, clock_target, cal_valid;
    logic [7:0] dio_in = 8'h00, reg_addr, dio_oe, dio_out;
    logic [17:0] adc_sample = 18'h0, sample_data;
    logic [18:0] buffer_count = 19'h0;
    logic [31:0] reg_wdata, reg_rdata, rv, d, seed = 32'hADAC7916;
    int fail_count = 0, checks = 0, cyc = 0, t0, t1, n, k;
    acqes_host h (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));
    acqes_top #(.CAL_NOFILT_CYCLES(20), .CAL_FILT_CYCLES(35)) u_dut (.clk_sys(clk_sys), .reset(reset), .ce(1'b1),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .adc_sample(adc_sample), .adc_valid(adc_valid), .sample_data(sample_data), .sample_valid(),
        .buffer_count(buffer_count), .buffer_fault(fault), .burst_end(1'b0), .ext_clock_in(ext_clk),
        .ext_trigger_in(1'b0), .sample_clock(sample_clock), .burst_trigger(), .clock_target(clock_target),
        .trigger_target(), .burst_active(), .high_rate_mode(), .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe),
        .cal_fail(cal_fail), .cal_running(cal_running), .cal_range(), .cal_filter(), .cal_valid(cal_valid));
    always #25 clk_sys = ~clk_sys;
    // Cycle count; a hang is cut short as a mismatch.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end
    // Xorshift source, compare, tick wait and verdict.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    task automatic tick(output int t);
        @(negedge clk_sys);
        for (k = 0; k < 40 && sample_clock !== 1'b1; k++) @(negedge clk_sys);
        t = cyc;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence of scenarios.
    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        d = rnd();
        h.rd(8'h1C, rv);
        chk("pacer_one", 32'h000001C2, rv);
        h.wr(8'h1C, d);
        h.wr(8'h20, ~d);
        h.rd(8'h1C, rv);
        chk("pacer_one", {8'h00, d[23:0]}, rv);
        h.rd(8'h20, rv);
        chk("pacer_two", {8'h00, ~d[23:0]}, rv);
        @(posedge clk_sys) dio_in <= {d[7:1], 1'b0};
        h.rd(8'h04, rv);
        chk("digital_port", {20'h0, dio_in[7:4], 4'h0, dio_in[3:0]}, rv);
        $display("end registers");
        n = 4 + int'(d[9:8]);
        h.wr(8'h1C, n);
        h.wr(8'h30, 32'h000000C8);
        h.wr(8'h00, 32'h00001058);
        tick(t0);
        tick(t1);
        chk("pacer_period", n, t1 - t0);
        @(posedge clk_sys) {dio_in[0], fault} <= 2'b11;
        @(posedge clk_sys) {dio_in[0], fault} <= 2'b00;
        h.wr(8'h00, 32'h00001008);
        repeat (2) @(posedge clk_sys);
        t0 = 0;
        repeat (20) @(negedge clk_sys) t0 += sample_clock;
        chk("pacer_stopped", 0, t0);
        h.rd(8'h30, rv);
        chk("event_status", 32'h00C800C8, rv);
        h.wr(8'h30, 32'h004000C0);
        h.rd(8'h30, rv);
        chk("event_status", 32'h004000C0, rv);
        h.wr(8'h30, 32'h00400080);
        h.rd(8'h30, rv);
        chk("event_status", 32'h00000080, rv);
        h.wr(8'h00, 32'h00001208);
        @(posedge clk_sys) ext_clk <= 1'b1;
        @(posedge clk_sys) #1 chk("ext_clock", 1, sample_clock);
        chk("clock_target", 1, clock_target);
        $display("end pacer and events");
        for (n = 0; n < 8; n++) begin
            if (n % 4 == 0) h.wr(8'h00, n < 4 ? 32'h00001008 : 32'h00001000);
            d = rnd();
            @(posedge clk_sys);
            {adc_sample, adc_valid, buffer_count} <= {d[17:0], 1'b1, d[31:13]};
            @(posedge clk_sys) adc_valid <= 1'b0;
            #1 chk("sample_data", n < 4 ? d[17:0] : {~d[17], d[16:0]}, sample_data);
        end
        @(posedge clk_sys) buffer_count <= 19'h3FFFF;
        h.rd(8'h2C, rv);
        chk("fill_flag", 32'h0013FFFE, rv);
        h.wr(8'h04, 32'h00000085);
        h.rd(8'h04, rv);
        chk("dio_oe", 8'h0F, dio_oe);
        $display("end coding and port");
        for (n = 0; n < 2; n++) begin
            @(posedge clk_sys) cal_fail <= (n == 0);
            h.wr(8'h30, 32'h00000001);
            h.wr(8'h00, n ? 32'h0000300A : 32'h0000100A);
            @(negedge clk_sys);
            for (k = 0; k < 100 && cal_running !== 1'b0; k++) @(negedge clk_sys);
            chk("cal_cycles", n ? 35 : 20, k);
            h.rd(8'h00, rv);
            chk("cal_pass", n, rv[2]);
            chk("cal_start", 0, rv[1]);
            h.rd(8'h30, rv);
            chk("cal_event", 32'h00010001, rv);
        end
        h.wr(8'h00, 32'h00000001);
        h.rd(8'h1C, rv);
        chk("init_pacer", 32'h000001C2, rv);
        chk("cal_valid", 1, cal_valid);
        $display("end calibration");
        summarize();
    end
endmodule
bind acqes_top acqes_top_chk #(.CAL_NOFILT_CYCLES(CAL_NOFILT_CYCLES), .CAL_FILT_CYCLES(CAL_FILT_CYCLES)) u_chk (
    .clk_sys(clk_sys), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .adc_valid(adc_valid),
    .sample_valid(sample_valid), .clock_target(clock_target), .cal_running(cal_running), .reg_addr(reg_addr),
    .dio_out(dio_out), .dio_oe(dio_oe), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
`default_nettype wire
